// *** core/pdg_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * port D..G pin function multiplexer.
 * Assumes byte addressing on an APB bus with 32-bit data words.
 */
`ifndef PDG_REGS_SVH
`define PDG_REGS_SVH

// register byte offsets
`define PDG_OFF_FUNC_D 8'h00
`define PDG_OFF_FUNC_E 8'h04
`define PDG_OFF_FUNC_F 8'h08
`define PDG_OFF_FUNC_G 8'h0C
`define PDG_OFF_DOUT 8'h10
`define PDG_OFF_DIR 8'h14
`define PDG_OFF_DIN 8'h18
`define PDG_OFF_CTRL 8'h1C
`define PDG_OFF_STATUS 8'h20

// port lanes inside the data-out, direction and data-in words
`define PDG_LANE_D 0
`define PDG_LANE_E 8
`define PDG_LANE_F 16
`define PDG_LANE_G 24

// control and status bits
`define PDG_CTRL_PWRDN 0
`define PDG_STAT_SELECT 0
`define PDG_STAT_PWRDN 1
`define PDG_STAT_UPPER_WR 2
`define PDG_STAT_ADDR_IN 4

// latched address bit that lands on pin 0 of each port
`define PDG_ADDR_BASE_E 0
`define PDG_ADDR_BASE_F 0
`define PDG_ADDR_BASE_G 8

// reset values: every pin back to general-purpose input
`define PDG_RST_FUNC 32'h0000_0000
`define PDG_RST_DOUT 32'h0000_0000
`define PDG_RST_DIR 32'h0000_0000

// synchroniser depth on pin inputs
`define PDG_SYNC_STAGES 2

`endif

// *** core/pdg_pkg.sv ***
/*
 * Types of the port D..G pin function multiplexer: per-port function codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pdg_pkg;

    typedef enum logic [1:0] {
        PDG_D_GPIO = 2'h0,
        PDG_D_PLD = 2'h1,
        PDG_D_SPECIAL = 2'h2
    } pdg_d_func_type;

    typedef enum logic [2:0] {
        PDG_E_GPIO = 3'h0,
        PDG_E_ADDR_OUT = 3'h1,
        PDG_E_JTAG = 3'h2,
        PDG_E_ISP_READY = 3'h3
    } pdg_e_func_type;

    typedef enum logic [2:0] {
        PDG_F_GPIO = 3'h0,
        PDG_F_EXT_SEL = 3'h1,
        PDG_F_LOGIC_IN = 3'h2,
        PDG_F_ADDR_OUT = 3'h3,
        PDG_F_ADDR_IN = 3'h4,
        PDG_F_DATA = 3'h5,
        PDG_F_PERIPH = 3'h6,
        PDG_F_HOST_RST = 3'h7
    } pdg_f_func_type;

    typedef enum logic [1:0] {
        PDG_G_GPIO = 2'h0,
        PDG_G_ADDR_OUT = 2'h1,
        PDG_G_DATA = 2'h2,
        PDG_G_HOST_RST = 2'h3
    } pdg_g_func_type;

endpackage : pdg_pkg

// *** core/pdg_reg_if.sv ***
/*
 * Carrier between the APB slave and the register file of the pin multiplexer.
 * Assumes both ends run on the same pclk.
 */
`timescale 1ns/100ps
interface pdg_reg_if;
    logic wr_en;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave (output wr_en, output addr, output wdata, input rdata);
    modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface : pdg_reg_if

// *** core/pdg_pin_sync.sv ***
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to pclk; only the second stage is read.
 */
`timescale 1ns/100ps
module pdg_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;
endmodule : pdg_pin_sync

// *** core/pdg_apb_slave.sv ***
/*
 * APB slave for the pin multiplexer registers: one wait state per transfer.
 * Assumes an APB master that holds its request until pready is seen high.
 */
`timescale 1ns/100ps
`include "pdg_regs.svh"
module pdg_apb_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    pdg_reg_if.slave rif
);
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic access;

    // aligned word at a mapped offset
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == 2'h0) && (a <= `PDG_OFF_STATUS);
    endfunction : addr_hit

    assign access = psel && penable;
    // the write lands on the edge where pready is sampled high
    assign rif.wr_en = access && pwrite && pready_q && addr_hit(paddr);
    assign rif.addr = paddr;
    assign rif.wdata = pwdata;

    // answer one cycle into the access phase; unmapped gives error and zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pready_q <= 1'b1;
            prdata_q <= (!pwrite && addr_hit(paddr)) ? rif.rdata : 32'h0000_0000;
            pslverr_q <= !addr_hit(paddr);
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    chk_apb_one_wait : assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
        else $error("apb answer not after exactly one wait state");
endmodule : pdg_apb_slave

// *** core/pdg_pin_mux.sv ***
/*
 * Pin function multiplexer for port D pins 2..3 and ports E, F and G.
 * Assumes internal logic (address latch, PLD, JTAG engine, memories) runs on
 * pclk; only the pins are asynchronous and pass two flip-flops.
 */
// What this block does
// - every pin selectable as plain host I/O
// - port D pins 2..3 as transparent PLD inputs
// - select input low enables memory access
// - select input high disables all memories
// - falling select edge wakes from power-down
// - port D pin 3 as upper-byte write strobe
// - port E pins 0..3 carry JTAG signals
// - port E pin 4 status or ready/busy
// - port E pin 5 active-low programming error
// - E, F, G pins output latched address bits
// - port F as select outputs or logic inputs
// - port F pins 1..3 take address 1..3
// - port F as low data byte
// - port G as high data byte
// - peripheral mode on F, host reset on F, G
// - low reset clears ports, aborts programming
`timescale 1ns/100ps
`include "pdg_regs.svh"
module pdg_pin_mux (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic port_d_pin2_in,
    output logic port_d_pin2_out,
    output logic port_d_pin2_oe,
    input wire logic port_d_pin3_in,
    output logic port_d_pin3_out,
    output logic port_d_pin3_oe,
    input wire logic [7:0] port_e_pins_in,
    output logic [7:0] port_e_pins_out,
    output logic [7:0] port_e_pins_oe,
    input wire logic [7:0] port_f_pins_in,
    output logic [7:0] port_f_pins_out,
    output logic [7:0] port_f_pins_oe,
    input wire logic [7:0] port_g_pins_in,
    output logic [7:0] port_g_pins_out,
    output logic [7:0] port_g_pins_oe,
    input wire logic [15:0] host_addr,
    input wire logic addr_latch,
    input wire logic [7:0] ext_select_out,
    input wire logic jtag_tdo,
    input wire logic jtag_tdo_en,
    input wire logic prog_status_out,
    input wire logic prog_error,
    input wire logic isp_ready,
    input wire logic [15:0] bus_rd_data,
    input wire logic bus_drive,
    input wire logic periph_drive,
    input wire logic host_reset,
    output logic [1:0] pld_d_in,
    output logic [7:0] general_logic_array_in,
    output logic mem_enable,
    output logic wake,
    output logic upper_byte_wr,
    output logic jtag_tms,
    output logic jtag_tck,
    output logic jtag_tdi,
    output logic [3:1] addr_in,
    output logic [15:0] bus_wr_data,
    output logic prog_abort
);
    import pdg_pkg::*;

    pdg_reg_if rif ();

    logic [1:0] d_sync;
    logic [7:0] e_sync;
    logic [7:0] f_sync;
    logic [7:0] g_sync;
    logic [3:0] func_d_q;
    logic [23:0] func_e_q;
    logic [23:0] func_f_q;
    logic [15:0] func_g_q;
    logic [31:0] dout_q;
    logic [31:0] dir_q;
    logic [15:0] addr_lat_q;
    logic pwrdn_q;
    logic sel_prev_q;
    logic sel_mode;
    logic wr_mode;
    logic sel_fall;
    logic [1:0] d_out_d, d_oe_d, d_out_q, d_oe_q;
    logic [7:0] e_out_d, e_oe_d, e_out_q, e_oe_q;
    logic [7:0] f_out_d, f_oe_d, f_out_q, f_oe_q;
    logic [7:0] g_out_d, g_oe_d, g_out_q, g_oe_q;
    logic [1:0] pld_d_q;
    logic [7:0] logic_in_q;
    logic mem_enable_q, wake_q, upper_wr_q;
    logic tms_q, tck_q, tdi_q, abort_q;
    logic [3:1] addr_in_q;
    logic [15:0] bus_wr_q;

    pdg_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .rif(rif.slave)
    );

    pdg_pin_sync #(.WIDTH(26)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({port_d_pin3_in, port_d_pin2_in, port_e_pins_in, port_f_pins_in, port_g_pins_in}),
        .pin_sync({d_sync, e_sync, f_sync, g_sync})
    );

    assign sel_mode = pdg_d_func_type'(func_d_q[1:0]) == PDG_D_SPECIAL;
    assign wr_mode = pdg_d_func_type'(func_d_q[3:2]) == PDG_D_SPECIAL;
    // synced select level is read, never the first synchroniser stage
    assign sel_fall = sel_mode && sel_prev_q && !d_sync[0];

    // function, data-out and direction registers; reset returns every pin to input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            func_d_q <= 4'(`PDG_RST_FUNC);
            func_e_q <= 24'h00_0000;
            func_f_q <= 24'h00_0000;
            func_g_q <= 16'h0000;
            dout_q <= `PDG_RST_DOUT;
            dir_q <= `PDG_RST_DIR;
        end else if (rif.wr_en) begin
            unique case (rif.addr)
                `PDG_OFF_FUNC_D: func_d_q <= rif.wdata[3:0];
                `PDG_OFF_FUNC_E: func_e_q <= rif.wdata[23:0];
                `PDG_OFF_FUNC_F: func_f_q <= rif.wdata[23:0];
                `PDG_OFF_FUNC_G: func_g_q <= rif.wdata[15:0];
                `PDG_OFF_DOUT: dout_q <= rif.wdata;
                `PDG_OFF_DIR: dir_q <= rif.wdata;
                default: ;
            endcase
        end
    end

    // power-down: software enters it, a select falling edge leaves it;
    // the wake wins over a write in the same cycle so no wake-up is lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwrdn_q <= 1'b0;
            sel_prev_q <= 1'b1;
        end else begin
            sel_prev_q <= d_sync[0];
            if (sel_fall) begin
                pwrdn_q <= 1'b0;
            end else if (rif.wr_en && rif.addr == `PDG_OFF_CTRL) begin
                pwrdn_q <= rif.wdata[`PDG_CTRL_PWRDN];
            end
        end
    end

    // register read mux; unused lanes read as zero
    always_comb begin
        rif.rdata = 32'h0000_0000;
        unique case (rif.addr)
            `PDG_OFF_FUNC_D: rif.rdata[3:0] = func_d_q;
            `PDG_OFF_FUNC_E: rif.rdata[23:0] = func_e_q;
            `PDG_OFF_FUNC_F: rif.rdata[23:0] = func_f_q;
            `PDG_OFF_FUNC_G: rif.rdata[15:0] = func_g_q;
            `PDG_OFF_DOUT: rif.rdata = dout_q;
            `PDG_OFF_DIR: rif.rdata = dir_q;
            `PDG_OFF_DIN: rif.rdata = {g_sync, f_sync, e_sync, 6'h00, d_sync};
            `PDG_OFF_CTRL: rif.rdata[`PDG_CTRL_PWRDN] = pwrdn_q;
            `PDG_OFF_STATUS: begin
                rif.rdata[`PDG_STAT_SELECT] = mem_enable_q;
                rif.rdata[`PDG_STAT_PWRDN] = pwrdn_q;
                rif.rdata[`PDG_STAT_UPPER_WR] = upper_wr_q;
                rif.rdata[`PDG_STAT_ADDR_IN+:3] = addr_in_q;
            end
            default: ;
        endcase
    end

    // address latch, captured on the host latch strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_lat_q <= 16'h0000;
        end else if (addr_latch) begin
            addr_lat_q <= host_addr;
        end
    end

    // pin drive per function; a pin carries exactly one function at a time
    for (genvar i = 0; i < 2; i++) begin : g_d
        always_comb begin
            d_out_d[i] = dout_q[`PDG_LANE_D+i];
            d_oe_d[i] = 1'b0;
            if (pdg_d_func_type'(func_d_q[2*i+:2]) == PDG_D_GPIO) begin
                d_oe_d[i] = dir_q[`PDG_LANE_D+i];
            end
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_e
        always_comb begin
            e_out_d[i] = dout_q[`PDG_LANE_E+i];
            e_oe_d[i] = 1'b0;
            unique case (pdg_e_func_type'(func_e_q[3*i+:3]))
                PDG_E_GPIO: e_oe_d[i] = dir_q[`PDG_LANE_E+i];
                PDG_E_ADDR_OUT: begin
                    e_out_d[i] = addr_lat_q[`PDG_ADDR_BASE_E+i];
                    e_oe_d[i] = 1'b1;
                end
                PDG_E_JTAG: begin
                    // pins 0..2 are inputs, 6..7 have no test role and float
                    if (i == 3) begin
                        e_out_d[i] = jtag_tdo;
                        e_oe_d[i] = jtag_tdo_en;
                    end else if (i == 4) begin
                        e_out_d[i] = prog_status_out;
                        e_oe_d[i] = 1'b1;
                    end else if (i == 5) begin
                        e_out_d[i] = !prog_error;
                        e_oe_d[i] = 1'b1;
                    end
                end
                PDG_E_ISP_READY: begin
                    if (i == 4) begin
                        e_out_d[i] = isp_ready;
                        e_oe_d[i] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_f
        always_comb begin
            f_out_d[i] = dout_q[`PDG_LANE_F+i];
            f_oe_d[i] = 1'b0;
            unique case (pdg_f_func_type'(func_f_q[3*i+:3]))
                PDG_F_GPIO: f_oe_d[i] = dir_q[`PDG_LANE_F+i];
                PDG_F_EXT_SEL: begin
                    f_out_d[i] = ext_select_out[i];
                    f_oe_d[i] = 1'b1;
                end
                PDG_F_ADDR_OUT: begin
                    f_out_d[i] = addr_lat_q[`PDG_ADDR_BASE_F+i];
                    f_oe_d[i] = 1'b1;
                end
                PDG_F_DATA: begin
                    f_out_d[i] = bus_rd_data[i];
                    f_oe_d[i] = bus_drive;
                end
                PDG_F_PERIPH: begin
                    f_out_d[i] = bus_rd_data[i];
                    f_oe_d[i] = periph_drive;
                end
                PDG_F_HOST_RST: begin
                    // open-drain low while the host is held in reset
                    f_out_d[i] = 1'b0;
                    f_oe_d[i] = host_reset;
                end
                default: ;
            endcase
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_g
        always_comb begin
            g_out_d[i] = dout_q[`PDG_LANE_G+i];
            g_oe_d[i] = 1'b0;
            unique case (pdg_g_func_type'(func_g_q[2*i+:2]))
                PDG_G_GPIO: g_oe_d[i] = dir_q[`PDG_LANE_G+i];
                PDG_G_ADDR_OUT: begin
                    g_out_d[i] = addr_lat_q[`PDG_ADDR_BASE_G+i];
                    g_oe_d[i] = 1'b1;
                end
                PDG_G_DATA: begin
                    g_out_d[i] = bus_rd_data[8+i];
                    g_oe_d[i] = bus_drive;
                end
                PDG_G_HOST_RST: begin
                    g_out_d[i] = 1'b0;
                    g_oe_d[i] = host_reset;
                end
                default: ;
            endcase
        end
    end

    // registered pin drivers; reset releases every pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            d_out_q <= 2'h0;
            d_oe_q <= 2'h0;
            e_out_q <= 8'h00;
            e_oe_q <= 8'h00;
            f_out_q <= 8'h00;
            f_oe_q <= 8'h00;
            g_out_q <= 8'h00;
            g_oe_q <= 8'h00;
        end else begin
            d_out_q <= d_out_d;
            d_oe_q <= d_oe_d;
            e_out_q <= e_out_d;
            e_oe_q <= e_oe_d;
            f_out_q <= f_out_d;
            f_oe_q <= f_oe_d;
            g_out_q <= g_out_d;
            g_oe_q <= g_oe_d;
        end
    end

    // inputs toward internal logic; unselected PLD and logic inputs read zero, JTAG and address inputs hold, the data word follows the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pld_d_q <= 2'h0;
            logic_in_q <= 8'h00;
            mem_enable_q <= 1'b1;
            wake_q <= 1'b0;
            upper_wr_q <= 1'b0;
            tms_q <= 1'b1;
            tck_q <= 1'b0;
            tdi_q <= 1'b1;
            addr_in_q <= 3'h0;
            bus_wr_q <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                pld_d_q[i] <= (pdg_d_func_type'(func_d_q[2*i+:2]) == PDG_D_PLD) && d_sync[i];
            end
            for (int i = 0; i < 8; i++) begin
                logic_in_q[i] <= (pdg_f_func_type'(func_f_q[3*i+:3]) == PDG_F_LOGIC_IN) && f_sync[i];
            end
            // memories run while the select input is low, and always when port D pin 2 is not in select mode
            mem_enable_q <= !sel_mode || !d_sync[0];
            wake_q <= sel_fall && pwrdn_q;
            upper_wr_q <= wr_mode && !d_sync[1];
            if (pdg_e_func_type'(func_e_q[2:0]) == PDG_E_JTAG) begin
                tms_q <= e_sync[0];
            end
            if (pdg_e_func_type'(func_e_q[5:3]) == PDG_E_JTAG) begin
                tck_q <= e_sync[1];
            end
            if (pdg_e_func_type'(func_e_q[8:6]) == PDG_E_JTAG) begin
                tdi_q <= e_sync[2];
            end
            for (int i = 1; i < 4; i++) begin
                if (pdg_f_func_type'(func_f_q[3*i+:3]) == PDG_F_ADDR_IN) begin
                    addr_in_q[i] <= f_sync[i];
                end
            end
            bus_wr_q <= {g_sync, f_sync};
        end
    end

    // programming abort: held through reset, dropped at the first edge after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_q <= 1'b1;
        end else begin
            abort_q <= 1'b0;
        end
    end

    assign port_d_pin2_out = d_out_q[0];
    assign port_d_pin2_oe = d_oe_q[0];
    assign port_d_pin3_out = d_out_q[1];
    assign port_d_pin3_oe = d_oe_q[1];
    assign port_e_pins_out = e_out_q;
    assign port_e_pins_oe = e_oe_q;
    assign port_f_pins_out = f_out_q;
    assign port_f_pins_oe = f_oe_q;
    assign port_g_pins_out = g_out_q;
    assign port_g_pins_oe = g_oe_q;
    assign pld_d_in = pld_d_q;
    assign general_logic_array_in = logic_in_q;
    assign mem_enable = mem_enable_q;
    assign wake = wake_q;
    assign upper_byte_wr = upper_wr_q;
    assign jtag_tms = tms_q;
    assign jtag_tck = tck_q;
    assign jtag_tdi = tdi_q;
    assign addr_in = addr_in_q;
    assign bus_wr_data = bus_wr_q;
    assign prog_abort = abort_q;

    chk_select_disables_mem : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_mode && d_sync[0]) |=> !mem_enable)
        else $error("memory still enabled with select high");
    chk_select_enables_mem : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_mode && !d_sync[0]) |=> mem_enable)
        else $error("memory disabled with select low");
    chk_wake_leaves_pwrdn : assert property (@(posedge pclk) disable iff (!presetn)
        (sel_fall && pwrdn_q) |=> (wake && !pwrdn_q) ##1 !wake)
        else $error("falling select did not wake exactly once");
    chk_upper_wr_strobe : assert property (@(posedge pclk) disable iff (!presetn)
        wr_mode && $fell(d_sync[1]) |=> upper_byte_wr)
        else $error("upper byte strobe not seen");
    chk_tdo_drive : assert property (@(posedge pclk) disable iff (!presetn)
        (pdg_e_func_type'(func_e_q[11:9]) == PDG_E_JTAG) |=> port_e_pins_oe[3] == $past(jtag_tdo_en))
        else $error("test data out enable wrong");
    chk_error_pin_low : assert property (@(posedge pclk) disable iff (!presetn)
        (pdg_e_func_type'(func_e_q[17:15]) == PDG_E_JTAG && prog_error)
        |=> (port_e_pins_oe[5] && !port_e_pins_out[5]))
        else $error("error pin not driven low");
    chk_addr_out_bit : assert property (@(posedge pclk) disable iff (!presetn)
        (pdg_g_func_type'(func_g_q[1:0]) == PDG_G_ADDR_OUT)
        |=> (port_g_pins_oe[0] && port_g_pins_out[0] == $past(addr_lat_q[`PDG_ADDR_BASE_G])))
        else $error("latched address bit not on port g");
    chk_data_low_drive : assert property (@(posedge pclk) disable iff (!presetn)
        (pdg_f_func_type'(func_f_q[2:0]) == PDG_F_DATA) |=> port_f_pins_oe[0] == $past(bus_drive))
        else $error("low data byte drive wrong");
    chk_gpio_dir : assert property (@(posedge pclk) disable iff (!presetn)
        (pdg_g_func_type'(func_g_q[15:14]) == PDG_G_GPIO) |=> port_g_pins_oe[7] == $past(dir_q[31]))
        else $error("gpio direction not followed");
endmodule : pdg_pin_mux

// *** dv/pdg_host_model.sv ***
/*
 * Host side of the pin multiplexer: resolves the shared port D, F and G wires.
 * Assumes the host drives every wire the device leaves undriven.
 */
`timescale 1ns/100ps
module pdg_host_model (
    input wire logic sel_n,
    input wire logic wr_hi_n,
    input wire logic [15:0] bus,
    input wire logic [1:0] d_out,
    input wire logic [1:0] d_oe,
    input wire logic [15:0] fg_out,
    input wire logic [15:0] fg_oe,
    output logic [1:0] d_in,
    output logic [15:0] fg_in
);
    // device level where it drives, host level elsewhere
    assign d_in = (d_oe & d_out) | (~d_oe & {wr_hi_n, sel_n});
    // pin 0 of port F is tied to ground by the host
    assign fg_in = (fg_oe & fg_out) | (~fg_oe & {bus[15:1], 1'b0});
endmodule : pdg_host_model

// *** dv/test_port_d_to_g_function_mux.sv ***
/*
 * Self-checking bench of the pin multiplexer, driven over APB.
 * Assumes the design's one-wait-state APB slave and two-flop pin sync.
 */
`timescale 1ns/100ps
`include "pdg_regs.svh"
module test_port_d_to_g_function_mux;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, w;
    logic [7:0] paddr = 8'h00, port_e_pins_in, ext_select_out, e_out, e_oe, general_logic_array_in;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic [15:0] host_addr, bus_rd_data, hbus, fg_in, fg_out, fg_oe, bus_wr_data;
    logic [1:0] d_in, d_out, d_oe, pld_d_in;
    logic [3:1] addr_in;
    logic addr_latch = 0, sel_n = 1, wr_n = 1, jtag_tdo, jtag_tdo_en, prog_status_out, prog_error;
    logic isp_ready, bus_drive = 0, periph_drive, host_reset, mem_enable, wake, upper_byte_wr;
    logic jtag_tms, jtag_tck, jtag_tdi, prog_abort;
    int err_count = 0, compares = 0, cycles = 0, i, seed = 98;
    pdg_pin_mux DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
        .pslverr, .port_d_pin2_in(d_in[0]), .port_d_pin2_out(d_out[0]), .port_d_pin2_oe(d_oe[0]),
        .port_d_pin3_in(d_in[1]), .port_d_pin3_out(d_out[1]), .port_d_pin3_oe(d_oe[1]),
        .port_e_pins_in, .port_e_pins_out(e_out), .port_e_pins_oe(e_oe),
        .port_f_pins_in(fg_in[7:0]), .port_f_pins_out(fg_out[7:0]), .port_f_pins_oe(fg_oe[7:0]),
        .port_g_pins_in(fg_in[15:8]), .port_g_pins_out(fg_out[15:8]), .port_g_pins_oe(fg_oe[15:8]),
        .host_addr, .addr_latch, .ext_select_out, .jtag_tdo, .jtag_tdo_en, .prog_status_out,
        .prog_error, .isp_ready, .bus_rd_data, .bus_drive, .periph_drive, .host_reset,
        .pld_d_in, .general_logic_array_in, .mem_enable, .wake, .upper_byte_wr, .jtag_tms,
        .jtag_tck, .jtag_tdi, .addr_in, .bus_wr_data, .prog_abort);
    pdg_host_model host (.sel_n, .wr_hi_n(wr_n), .bus(hbus), .d_out, .d_oe, .fg_out, .fg_oe,
        .d_in, .fg_in);
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // one APB transfer; request held until pready is seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task final_report;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    initial forever #2.5 pclk = ~pclk;
    // a hang counts as a mismatch
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        {host_addr, bus_rd_data} = $random(seed);
        {hbus, port_e_pins_in, ext_select_out} = $random(seed);
        {jtag_tdo, jtag_tdo_en, prog_status_out, prog_error, isp_ready, periph_drive, host_reset} = 7'($random(seed));
        repeat (8) @(posedge pclk);
        chk("abort_rst", {prog_abort, e_oe, fg_oe}, {1'b1, 24'h00_0000});
        presetn <= 1;
        repeat (2) @(posedge pclk);
        chk("abort", prog_abort, 0);
        // reset values and the unmapped word past the map; pin input word skipped
        for (i = 0; i < 10; i++) begin
            apb(0, 8'(i * 4), 0);
            if (i != 6) chk("reg", rd, (i == 8) ? 32'h1 : 32'h0);
            chk("slverr", err, i == 9);
        end
        r = $random(seed);
        apb(1, `PDG_OFF_DIR, 32'hFFFF_FFFF);
        apb(1, `PDG_OFF_DOUT, r);
        repeat (3) @(posedge pclk);
        chk("gpio", {fg_out, e_out, d_out}, {r[31:8], r[1:0]});
        chk("gpio_oe", {fg_oe, e_oe, d_oe}, 32'h03FF_FFFF);
        apb(1, `PDG_OFF_DIR, 0);
        apb(1, `PDG_OFF_FUNC_E, 32'h0024_9249);
        apb(1, `PDG_OFF_FUNC_G, 32'h0000_5555);
        @(posedge pclk) addr_latch <= 1;
        @(posedge pclk) addr_latch <= 0;
        host_addr <= ~host_addr;
        repeat (4) @(posedge pclk);
        chk("addr", {fg_out[15:8], e_out, fg_oe[15:8], e_oe}, {~host_addr, 16'hFFFF});
        // data bus: host writes, then device drives the read word
        apb(1, `PDG_OFF_FUNC_F, 32'h00B6_DB6D);
        apb(1, `PDG_OFF_FUNC_G, 32'h0000_AAAA);
        repeat (5) @(posedge pclk);
        chk("wr_data", bus_wr_data, {hbus[15:1], 1'b0});
        bus_drive <= 1;
        repeat (3) @(posedge pclk);
        chk("rd_data", {fg_out, fg_oe}, {bus_rd_data, 16'hFFFF});
        apb(1, `PDG_OFF_FUNC_E, 32'h0001_2492);
        apb(1, `PDG_OFF_FUNC_D, 32'h0000_000A);
        repeat (5) @(posedge pclk);
        chk("jtag", {jtag_tdi, jtag_tck, jtag_tms, e_out[5]}, {port_e_pins_in[2:0], ~prog_error});
        chk("mem_off", mem_enable, 0);
        prog_error <= 1;
        apb(1, `PDG_OFF_CTRL, 1);
        @(posedge pclk) sel_n <= 0;
        wr_n <= 0;
        w = 0;
        repeat (8) @(posedge pclk) w |= (wake === 1'b1);
        chk("wake", w, 1);
        chk("mem_on", {mem_enable, upper_byte_wr}, 2'b11);
        apb(0, `PDG_OFF_STATUS, 0);
        chk("status", rd[2:0], 3'b101);
        chk("err_pin", {e_oe[5], e_out[5]}, 2'b10);
        // remaining modes: PLD inputs, mixed port F codes, ready/busy, host reset
        sel_n <= 1;
        apb(1, `PDG_OFF_FUNC_D, 32'h0000_0005);
        apb(1, `PDG_OFF_FUNC_F, 32'h007F_2921);
        apb(1, `PDG_OFF_FUNC_E, 32'h0000_3000);
        apb(1, `PDG_OFF_FUNC_G, 32'h0000_FFFF);
        repeat (5) @(posedge pclk);
        chk("pld_d", {mem_enable, pld_d_in}, 3'b101);
        chk("f_oe", fg_oe, {{8{host_reset}}, 1'b1, host_reset, periph_drive, 5'h01});
        chk("g_rst", fg_out[15:8], 0);
        chk("f_out", {fg_out[7:5], fg_out[0]}, {~host_addr[7], 1'b0, bus_rd_data[5], ext_select_out[0]});
        chk("f_in", {addr_in, general_logic_array_in}, {hbus[3:1], 3'h0, hbus[4], 4'h0});
        chk("isp", {e_oe, e_out[4]}, {8'h10, isp_ready});
        final_report();
    end
endmodule : test_port_d_to_g_function_mux
